// file: logic/serial_port_pin_mux_params.svh
// Register map and field positions of the serial port pin mux.
// Notes on behaviour
// - Receive line bits shift into an eight-bit receive shift register.
// - Receive line sampled on rising or falling clock edge per control bit.
// - Transmit data changes on rising edge by default; control bit reverses polarity.
// - Clock source select bit sets communications clock pin direction and function.
// - Async mode divides clock pin for baud; sync mode clocks directly from pin.
// - Each shared line is a plain GPIO bit when its serial role is off.
// - After reset every shared line is a GPIO input with serial roles off.
// - In sync mode the first flag line is a general serial I/O flag.
// - In async mode the first flag line is a clock input or output.
// - In async mode the second flag line is a frame-sync input or output.
// - In sync continuous-clock mode the second flag line is a flag like the first.
// - Both flag lines are independently controlled yet usable together as a device select.
// - The frame line only carries frame sync, direction set by sync control bit SY_FRAME_OUT in both modes.
// - The bit clock line carries the sync interface bit clock in single-clock mode.
`ifndef SERIAL_PORT_PIN_MUX_PARAMS_SVH
`define SERIAL_PORT_PIN_MUX_PARAMS_SVH
`define PORT_CTRL_ADDR      8'h00
`define GPIO_DIR_ADDR       8'h04
`define GPIO_OUT_ADDR       8'h08
`define GPIO_IN_ADDR        8'h0C
`define COMM_CTRL_ADDR      8'h10
`define CLK_CTRL_ADDR       8'h14
`define SYNC_CTRL_ADDR      8'h18
`define TX_DATA_ADDR        8'h1C
`define RX_DATA_ADDR        8'h20
`define STATUS_ADDR         8'h24
`define ADDR_W              8
`define LINES               7
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define CC_RX_FALL          0
`define CC_TX_INV           1
`define CC_SYNC_MODE        2
`define CK_SRC_SEL          0
`define CK_DIV_LSB          8
`define CK_DIV_W            8
`define SY_FLAG0_OUT        0
`define SY_FLAG1_OUT        1
`define SY_FLAG0_VAL        2
`define SY_FLAG1_VAL        3
`define SY_FRAME_OUT        4
`define SY_FRAME_VAL        5
`define SY_BCLK_OUT         6
`define SY_CONT_CLK         7
`define ST_RX_FULL          0
`define ST_TX_BUSY          1
`define BYTE_BITS           8
`define BIT_CNT_W           4
`endif

// file: logic/serial_port_pin_mux_pkg.sv
// Types shared by the serial port pin mux.
package serial_port_pin_mux_pkg;
  typedef struct packed {
    logic [6:0] in;
    logic [6:0] out;
    logic [6:0] oe;
  } pins_s;
  typedef struct packed {
    logic rx_fall;
    logic tx_inv;
    logic sync_mode;
  } comm_ctrl_s;
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_e;
endpackage

// file: logic/serial_port_pin_mux.sv
// Seven-line port mux with async comm interface, sync serial lines and AXI4-Lite registers.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "serial_port_pin_mux_params.svh"
module serial_port_pin_mux (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic                      link_clk,
  input  wire logic [`ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [`LINES-1:0]         pin_in,
  output logic      [`LINES-1:0]         pin_out,
  output logic      [`LINES-1:0]         pin_oe
);
  // Line map: 0 rx, 1 tx, 2 comm clock, 3 flag0, 4 flag1, 5 frame, 6 bit clock.

  ////////////////////////////////////////////////////////////////////////////
  logic [`LINES-1:0]     port_ctrl;
  logic [`LINES-1:0]     gpio_dir;
  logic [`LINES-1:0]     gpio_out;
  serial_port_pin_mux_pkg::comm_ctrl_s comm_ctrl;
  logic                  clk_src_sel;
  logic [`CK_DIV_W-1:0]  clk_div;
  logic [7:0]            sync_ctrl;
  logic [`BYTE_BITS-1:0] tx_data;
  logic                  tx_req;
  logic [`LINES-1:0]     pin_s1;
  logic [`LINES-1:0]     pin_s2;
  logic [`BYTE_BITS-1:0] rx_data;
  logic                  rx_full;
  logic                  aw_held;
  logic                  w_held;
  logic [`ADDR_W-1:0]    aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  serial_port_pin_mux_pkg::rd_state_e rd_state;
  logic                  tx_busy_sys;
  logic                  comm_clk_l;

  function automatic logic addr_known(input logic [`ADDR_W-1:0] a);
    addr_known = (a <= `STATUS_ADDR) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order.
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register stores; the low byte lane carries every field except the clock divider, which takes the second lane.
  wire wr_lo = do_write && w_strb[0];
  wire wr_hi = do_write && w_strb[1];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      port_ctrl   <= '0;
      gpio_dir    <= '0;
      gpio_out    <= '0;
      comm_ctrl   <= '0;
      clk_src_sel <= 1'b0;
      clk_div     <= '0;
      sync_ctrl   <= '0;
      tx_data     <= '0;
    end else begin
      if (wr_lo && aw_addr == `PORT_CTRL_ADDR) begin
        port_ctrl <= w_data[`LINES-1:0];
      end else if (wr_lo && aw_addr == `GPIO_DIR_ADDR) begin
        gpio_dir <= w_data[`LINES-1:0];
      end else if (wr_lo && aw_addr == `GPIO_OUT_ADDR) begin
        gpio_out <= w_data[`LINES-1:0];
      end else if (wr_lo && aw_addr == `COMM_CTRL_ADDR) begin
        comm_ctrl.rx_fall   <= w_data[`CC_RX_FALL];
        comm_ctrl.tx_inv    <= w_data[`CC_TX_INV];
        comm_ctrl.sync_mode <= w_data[`CC_SYNC_MODE];
      end else if (aw_addr == `CLK_CTRL_ADDR) begin
        if (wr_lo) begin
          clk_src_sel <= w_data[`CK_SRC_SEL];
        end
        if (wr_hi) begin
          clk_div <= w_data[`CK_DIV_LSB +: `CK_DIV_W];
        end
      end else if (wr_lo && aw_addr == `SYNC_CTRL_ADDR) begin
        sync_ctrl <= w_data[7:0];
      end else if (wr_lo && aw_addr == `TX_DATA_ADDR) begin
        tx_data <= w_data[`BYTE_BITS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == `PORT_CTRL_ADDR) begin
      rd_word[`LINES-1:0] = port_ctrl;
    end else if (s_axi_araddr == `GPIO_DIR_ADDR) begin
      rd_word[`LINES-1:0] = gpio_dir;
    end else if (s_axi_araddr == `GPIO_OUT_ADDR) begin
      rd_word[`LINES-1:0] = gpio_out;
    end else if (s_axi_araddr == `GPIO_IN_ADDR) begin
      rd_word[`LINES-1:0] = pin_s2;
    end else if (s_axi_araddr == `COMM_CTRL_ADDR) begin
      rd_word[`CC_RX_FALL]   = comm_ctrl.rx_fall;
      rd_word[`CC_TX_INV]    = comm_ctrl.tx_inv;
      rd_word[`CC_SYNC_MODE] = comm_ctrl.sync_mode;
    end else if (s_axi_araddr == `CLK_CTRL_ADDR) begin
      rd_word[`CK_SRC_SEL] = clk_src_sel;
      rd_word[`CK_DIV_LSB +: `CK_DIV_W] = clk_div;
    end else if (s_axi_araddr == `SYNC_CTRL_ADDR) begin
      rd_word[7:0] = sync_ctrl;
    end else if (s_axi_araddr == `TX_DATA_ADDR) begin
      rd_word[`BYTE_BITS-1:0] = tx_data;
    end else if (s_axi_araddr == `RX_DATA_ADDR) begin
      rd_word[`BYTE_BITS-1:0] = rx_data;
    end else if (s_axi_araddr == `STATUS_ADDR) begin
      rd_word[`ST_RX_FULL] = rx_full;
      rd_word[`ST_TX_BUSY] = tx_busy_sys;
    end
  end

  wire rx_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `RX_DATA_ADDR);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_state      <= serial_port_pin_mux_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      case (rd_state)
        serial_port_pin_mux_pkg::RD_IDLE: begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            rd_state      <= serial_port_pin_mux_pkg::RD_RESP;
          end
        end
        serial_port_pin_mux_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= serial_port_pin_mux_pkg::RD_IDLE;
          end
        end
        default: rd_state <= serial_port_pin_mux_pkg::RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser into the system domain.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain. The link clock times serial bits; the clock pin is sampled in it.
  logic [2:0] lrst_sync;
  wire        lrstn = lrst_sync[2];
  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[1:0], rstn};
  end

  // Level controls cross with two flops.
  logic [3:0] cfg_l1;
  logic [3:0] cfg_l2;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      cfg_l1 <= '0;
      cfg_l2 <= '0;
    end else begin
      cfg_l1 <= {port_ctrl[0], comm_ctrl.rx_fall, comm_ctrl.tx_inv, comm_ctrl.sync_mode};
      cfg_l2 <= cfg_l1;
    end
  end
  wire rx_en_l   = cfg_l2[3];
  wire rx_fall_l = cfg_l2[2];
  wire tx_inv_l  = cfg_l2[1];
  wire sync_l    = cfg_l2[0];

  logic [2:0] lpin1;
  logic [2:0] lpin2;
  logic       sclk_d;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      lpin1  <= '0;
      lpin2  <= '0;
      sclk_d <= 1'b0;
    end else begin
      lpin1  <= pin_in[2:0];
      lpin2  <= lpin1;
      sclk_d <= comm_clk_l;
    end
  end

  // Internal baud clock when the clock pin is an output.
  logic [`CK_DIV_W-1:0] div_cnt;
  logic                 baud_clk;
  logic [`CK_DIV_W-1:0] div_l;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      div_cnt  <= '0;
      baud_clk <= 1'b0;
      div_l    <= '0;
    end else begin
      div_l <= clk_div;
      if (div_cnt >= div_l) begin
        div_cnt  <= '0;
        baud_clk <= !baud_clk;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // Pin clock drives sync transfers directly; async divides it by two per bit.
  logic src_l;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      src_l <= 1'b0;
    end else begin
      src_l <= clk_src_sel;
    end
  end
  assign comm_clk_l = src_l ? baud_clk : lpin2[2];
  wire rise_l     = comm_clk_l && !sclk_d;
  wire fall_l     = !comm_clk_l && sclk_d;
  logic half_l;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      half_l <= 1'b0;
    end else if (rise_l) begin
      half_l <= !half_l;
    end
  end
  wire bit_rise = rise_l && (sync_l || half_l);
  wire bit_fall = fall_l && (sync_l || half_l);
  wire rx_edge  = rx_fall_l ? bit_fall : bit_rise;
  wire tx_edge  = tx_inv_l ? bit_fall : bit_rise;

  // Receive shift register; each full byte is passed by toggle.
  logic [`BYTE_BITS-1:0] rx_shift;
  logic [`BIT_CNT_W-1:0] rx_cnt;
  logic [`BYTE_BITS-1:0] rx_hold;
  logic                  rx_tog;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      rx_shift <= '0;
      rx_cnt   <= '0;
      rx_hold  <= '0;
      rx_tog   <= 1'b0;
    end else if (rx_en_l && rx_edge) begin
      rx_shift <= {lpin2[0], rx_shift[`BYTE_BITS-1:1]};
      if (rx_cnt == `BIT_CNT_W'(`BYTE_BITS - 1)) begin
        rx_cnt  <= '0;
        rx_hold <= {lpin2[0], rx_shift[`BYTE_BITS-1:1]};
        rx_tog  <= !rx_tog;
      end else begin
        rx_cnt <= rx_cnt + 1'b1;
      end
    end
  end

  // Transmit request toggles into the link domain on each data write.
  logic tx_tog_sys;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_tog_sys <= 1'b0;
    end else if (wr_lo && aw_addr == `TX_DATA_ADDR) begin
      tx_tog_sys <= !tx_tog_sys;
    end
  end
  assign tx_req = tx_tog_sys;

  logic [2:0]            tx_tog_l;
  logic [`BYTE_BITS-1:0] tx_shift;
  logic [`BIT_CNT_W-1:0] tx_cnt;
  logic                  tx_busy_l;
  logic                  tx_line;
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      tx_tog_l  <= '0;
      tx_shift  <= '0;
      tx_cnt    <= '0;
      tx_busy_l <= 1'b0;
      tx_line   <= 1'b1;
    end else begin
      tx_tog_l <= {tx_tog_l[1:0], tx_req};
      // Data is stable here: software must not rewrite it while busy shows.
      if (tx_tog_l[2] != tx_tog_l[1] && !tx_busy_l) begin
        tx_shift  <= tx_data;
        tx_cnt    <= '0;
        tx_busy_l <= 1'b1;
      end else if (tx_busy_l && tx_edge) begin
        tx_line  <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[`BYTE_BITS-1:1]};
        if (tx_cnt == `BIT_CNT_W'(`BYTE_BITS - 1)) begin
          tx_busy_l <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link results back into the system domain.
  logic [2:0] rx_tog_s;
  logic [1:0] busy_s;
  logic [1:0] txl_s;
  logic [1:0] bclk_s;
  assign tx_busy_sys = busy_s[1];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_tog_s <= '0;
      busy_s   <= '0;
      txl_s    <= 2'h3;
      bclk_s   <= '0;
      rx_data  <= '0;
      rx_full  <= 1'b0;
    end else begin
      rx_tog_s <= {rx_tog_s[1:0], rx_tog};
      busy_s   <= {busy_s[0], tx_busy_l};
      txl_s    <= {txl_s[0], tx_line};
      bclk_s   <= {bclk_s[0], baud_clk};
      if (rx_tog_s[2] != rx_tog_s[1]) begin
        rx_data <= rx_hold;
        rx_full <= 1'b1;
      end else if (rx_read) begin
        rx_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output mux; serial role when the line's port control bit is set.
  logic [`LINES-1:0] ser_out;
  logic [`LINES-1:0] ser_oe;
  always_comb begin
    ser_out = '0;
    ser_oe  = '0;
    ser_out[1] = txl_s[1];
    ser_oe[1]  = 1'b1;
    ser_out[2] = bclk_s[1];
    ser_oe[2]  = clk_src_sel;
    if (comm_ctrl.sync_mode) begin
      ser_out[3] = sync_ctrl[`SY_FLAG0_VAL];
      ser_oe[3]  = sync_ctrl[`SY_FLAG0_OUT];
      ser_out[4] = sync_ctrl[`SY_FLAG1_VAL];
      ser_oe[4]  = sync_ctrl[`SY_FLAG1_OUT] && sync_ctrl[`SY_CONT_CLK];
    end else begin
      ser_out[3] = bclk_s[1];
      ser_oe[3]  = sync_ctrl[`SY_FLAG0_OUT];
      ser_out[4] = sync_ctrl[`SY_FRAME_VAL];
      ser_oe[4]  = sync_ctrl[`SY_FLAG1_OUT];
    end
    ser_out[5] = sync_ctrl[`SY_FRAME_VAL];
    ser_oe[5]  = sync_ctrl[`SY_FRAME_OUT];
    ser_out[6] = bclk_s[1];
    ser_oe[6]  = sync_ctrl[`SY_BCLK_OUT];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      for (int i = 0; i < `LINES; i++) begin
        pin_out[i] <= port_ctrl[i] ? ser_out[i] : gpio_out[i];
        pin_oe[i]  <= port_ctrl[i] ? ser_oe[i] : gpio_dir[i];
      end
    end
  end
endmodule // serial_port_pin_mux

// file: dv/serial_port_pin_mux_props.sv
// Concurrent checks on the register bus and pin outputs of the serial port pin mux.
`timescale 1ns/1ps
`include "serial_port_pin_mux_params.svh"
module serial_port_pin_mux_props (
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [`LINES-1:0]  pin_out,
  input wire logic [`LINES-1:0]  pin_oe
);
  logic [3:0] since_w;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin enables may only move shortly after a register write lands.
  always_ff @(posedge sys_clk) begin
    if (!rstn || (s_axi_wvalid && s_axi_wready)) begin
      since_w <= 4'h0;
    end else if (since_w != 4'hF) begin
      since_w <= since_w + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_release_quiet: assert property ($rose(rstn) |-> pin_oe == '0 && pin_out == '0 && !s_axi_bvalid)
    else $error("pins or response active at reset release");
  a_early_idle: assert property ($rose(rstn) |-> (pin_oe == '0) [*2])
    else $error("pin driven before any write could land");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not offered one cycle after address");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data offered twice");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response offered twice");
  a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {`RESP_OKAY, `RESP_SLVERR})
    else $error("bad read response code");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {`RESP_OKAY, `RESP_SLVERR})
    else $error("bad write response code");
  a_oe_cause: assert property ($changed(pin_oe) |-> since_w <= 4'h8)
    else $error("pin enable moved without a write");
endmodule // serial_port_pin_mux_props

bind serial_port_pin_mux serial_port_pin_mux_props u_props (
  .sys_clk(sys_clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_out(pin_out), .pin_oe(pin_oe)
);

// file: dv/serial_peer.sv
// External serial device model: drives receive data and the comm clock, watches the transmit line.
`timescale 1ns/1ps
module serial_peer (
  input  wire logic [6:0] pins,
  output logic      [6:0] drive
);
  initial drive = 7'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // The data line carries the inverted bit around the wrong edge, so a device on the wrong edge reads garbage.
  task automatic send_rx(input logic [7:0] b, input logic fall);
    for (int i = 0; i < 8; i++) begin
      drive[0] = b[i] ^ fall;
      #40;
      drive[2] = 1'b1;
      #40;
      drive[0] = b[i] ^ !fall;
      #40;
      drive[2] = 1'b0;
      #40;
    end
    drive[0] = !drive[0];
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Runs the clock and samples the line just before each falling edge.
  // The byte must be complete at count 8 when rise is set and 7 otherwise, so a line launched on the wrong edge lands one sample off.
  task automatic watch_tx(input logic [7:0] exp, input logic rise, output logic seen);
    logic [7:0] sr = 8'h00;
    seen = 1'b0;
    for (int i = 0; i < 10; i++) begin
      #80;
      drive[2] = 1'b1;
      #80;
      sr = {pins[1], sr[7:1]};
      drive[2] = 1'b0;
      if (i == (rise ? 8 : 7) && sr === exp) seen = 1'b1;
    end
  endtask
endmodule // serial_peer

// file: dv/tb_top.sv
// Self-checking bench for the serial port pin mux.
`timescale 1ns/1ps
`include "serial_port_pin_mux_params.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = '0;
  logic [7:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic [6:0]  pin_in, pin_out, pin_oe, peer_lines;
  logic        seen;
  int          miscompares = 0;
  int          n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & peer_lines);
  serial_port_pin_mux uut (
    .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe)
  );
  serial_peer u_peer (.pins(pin_in), .drive(peer_lines));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    rr = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(32'(pin_oe), 32'h0);
    rdr(`PORT_CTRL_ADDR);
    chk(rd, 32'h0);
    rdr(8'h3C);
    chk(32'(rr), 32'(`RESP_SLVERR));
  endtask
  task automatic t_gpio();
    wr(`GPIO_DIR_ADDR, 32'h7F);
    wr(`GPIO_OUT_ADDR, 32'h2A);
    chk(32'(pin_oe), 32'h7F);
    chk(32'(pin_out), 32'h2A);
    wr(`GPIO_DIR_ADDR, 32'h00);
    u_peer.drive = 7'h49;
    repeat (4) @(posedge sys_clk);
    rdr(`GPIO_IN_ADDR);
    chk(rd & 32'h7F, 32'h49);
  endtask
  // Sync mode on the external clock, once per sampling edge, with bytes whose mirror is wrong.
  task automatic t_rx();
    logic [7:0] b;
    int n;
    wr(`CLK_CTRL_ADDR, 32'h0);
    wr(`PORT_CTRL_ADDR, 32'h07);
    for (int f = 0; f < 2; f++) begin
      b = f ? 8'hB2 : 8'h4D;
      wr(`COMM_CTRL_ADDR, 32'h4 | 32'(f));
      chk(32'(pin_oe[0]), 32'h0);
      u_peer.send_rx(b, f[0]);
      @(posedge sys_clk);
      n = 0;
      do begin
        rdr(`STATUS_ADDR);
        n++;
      end while (rd[0] !== 1'b1 && n < 20);
      chk(32'(rd[0]), 32'h1);
      rdr(`RX_DATA_ADDR);
      chk(rd & 32'hFF, 32'(b));
    end
  endtask
  task automatic t_tx();
    for (int v = 0; v < 2; v++) begin
      wr(`COMM_CTRL_ADDR, 32'h4 | (32'(v) << 1));
      wr(`TX_DATA_ADDR, 32'hA5);
      chk(32'(pin_oe[1]), 32'h1);
      u_peer.watch_tx(8'hA5, v[0], seen);
      @(posedge sys_clk);
      chk(32'(seen), 32'h1);
    end
  endtask
  task automatic t_clk_src();
    logic last;
    int tg = 0;
    wr(`CLK_CTRL_ADDR, 32'h0101);
    chk(32'(pin_oe[2]), 32'h1);
    last = pin_out[2];
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (pin_out[2] !== last) tg++;
      last = pin_out[2];
    end
    chk(32'(tg != 0), 32'h1);
    wr(`CLK_CTRL_ADDR, 32'h0);
    chk(32'(pin_oe[2]), 32'h0);
  endtask
  // Flag, frame and bit clock lines; in sync mode flag1 only drives with the continuous clock set.
  task automatic t_flags();
    logic [7:0] ctl [3] = '{8'hF7, 8'h0B, 8'h8E};
    logic [3:0] eoe [3] = '{4'hF, 4'h1, 4'h2};
    logic [2:0] eout [3] = '{3'h5, 3'h0, 3'h2};
    wr(`PORT_CTRL_ADDR, 32'h78);
    for (int i = 0; i < 3; i++) begin
      wr(`SYNC_CTRL_ADDR, 32'(ctl[i]));
      chk(32'(pin_oe[6:3]), 32'(eoe[i]));
      chk(32'(pin_out[5:3] & pin_oe[5:3]), 32'(eout[i]));
    end
    wr(`COMM_CTRL_ADDR, 32'h0);
    wr(`SYNC_CTRL_ADDR, 32'h23);
    chk(32'(pin_oe[6:3]), 32'h3);
    chk(32'(pin_out[4]), 32'h1);
    wr(`PORT_CTRL_ADDR, 32'h0);
    chk(32'(pin_oe), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_gpio();
    t_rx();
    t_tx();
    t_clk_src();
    t_flags();
    final_report();
  end
endmodule // tb_top
